/* File: design/dobs_sequencer.sv */
// demo output blinker sequencer: init outputs, wait supplies good, flash two patterns
// assumes analog_supplies_good is synchronous to clk; pins resolved by enables outside
//
// How it works
// (RULE1) after reset enter first step, advance one step at a time in order
// (RULE2) init step drives outputs 4,6 high and 5,7,8,9,14 low
// (RULE3) next step sets odd outputs 5..13 to 1, even 4..14 to 0
// (RULE4) value 0 leaves pin floating, value 1 pulls pin to ground
// (RULE5) hold that pattern until supplies good, then advance
// (RULE6) first loop step sets even outputs 4..14 to 1, odd to 0
// (RULE7) after each pattern loop step wait about half a second on timer
// (RULE8) second loop step sets output 3 and odd 5..13 to 1, even to 0
// (RULE9) after second delay jump back to first loop step, forever
`timescale 1ns/1ps
module dobs_sequencer #(
	parameter int unsigned DELAY_CYC = dobs_pkg::LOOP_DELAY_CYC
) (
	input wire logic clk, // 25 MHz clock
	input wire logic rst, // synchronous reset, active high
	input wire logic analog_supplies_good, // supplies good level
	output logic [14:0] seq_output_out, // pin level driven, always 0
	output logic [14:0] seq_output_oe, // pin pulled to ground when high
	output logic [14:0] seq_output_val // logical output value
);
	dobs_pkg::dobs_state_t state_reg, state_next;
	logic [14:0] pat_reg, pat_next;
	logic [31:0] tmr_reg, tmr_next;
	logic [14:0] oe_reg;
	logic [31:0] hold_cnt_reg;
	wire tmr_done = (tmr_reg == DELAY_CYC - 1);
	// a step that writes a different pattern restarts the pattern age
	wire pat_change = (pat_next != pat_reg);

	// shared by both delay steps and by the pattern-age counter
	function automatic logic [31:0] count_up(input logic [31:0] v);
		return v + 32'h0000_0001;
	endfunction

	always_comb begin
		state_next = state_reg;
		pat_next = pat_reg;
		tmr_next = 32'h0000_0000;
		unique case (state_reg)
			dobs_pkg::DOBS_ST_START: begin
				state_next = dobs_pkg::DOBS_ST_INIT; // see (RULE1)
			end
			dobs_pkg::DOBS_ST_INIT: begin
				// only 4..9,14 are touched; the rest keep reset value 0
				pat_next = dobs_pkg::PAT_INIT; // see (RULE2)
				state_next = dobs_pkg::DOBS_ST_WAIT_GOOD;
			end
			dobs_pkg::DOBS_ST_WAIT_GOOD: begin
				pat_next = dobs_pkg::PAT_ODD; // see (RULE3)
				if (analog_supplies_good && pat_reg == dobs_pkg::PAT_ODD) begin
					state_next = dobs_pkg::DOBS_ST_EVEN; // see (RULE5)
				end
			end
			dobs_pkg::DOBS_ST_EVEN: begin
				pat_next = dobs_pkg::PAT_EVEN; // see (RULE6)
				state_next = dobs_pkg::DOBS_ST_DELAY1;
			end
			dobs_pkg::DOBS_ST_DELAY1: begin
				tmr_next = count_up(tmr_reg); // see (RULE7)
				if (tmr_done) begin
					tmr_next = 32'h0000_0000;
					state_next = dobs_pkg::DOBS_ST_ODD;
				end
			end
			dobs_pkg::DOBS_ST_ODD: begin
				pat_next = dobs_pkg::PAT_ODD3; // see (RULE8)
				state_next = dobs_pkg::DOBS_ST_DELAY2;
			end
			dobs_pkg::DOBS_ST_DELAY2: begin
				tmr_next = count_up(tmr_reg); // see (RULE7)
				if (tmr_done) begin
					tmr_next = 32'h0000_0000;
					state_next = dobs_pkg::DOBS_ST_EVEN; // see (RULE9)
				end
			end
			default: begin
				state_next = dobs_pkg::DOBS_ST_START;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= dobs_pkg::DOBS_ST_START;
			pat_reg <= dobs_pkg::PAT_RESET;
			tmr_reg <= 32'h0000_0000;
			oe_reg <= dobs_pkg::PAT_RESET;
		end else begin
			state_reg <= state_next;
			pat_reg <= pat_next;
			tmr_reg <= tmr_next;
			oe_reg <= pat_next; // see (RULE4)
		end
	end

	// open drain: never drive high, so the level is always 0
	assign seq_output_out = 15'h0000;
	assign seq_output_oe = oe_reg;
	assign seq_output_val = pat_reg;

	property p_rule1;
		@(posedge clk) disable iff (rst)
		// rst sampled too: the edge that releases it still leaves the state in START
		!rst && state_reg == dobs_pkg::DOBS_ST_START |=> state_reg == dobs_pkg::DOBS_ST_INIT;
	endproperty
	a_rule1: assert property (p_rule1) else $error("start did not go to init"); // see (RULE1)

	property p_rule2;
		@(posedge clk) disable iff (rst)
		state_reg == dobs_pkg::DOBS_ST_INIT |=> pat_reg == dobs_pkg::PAT_INIT;
	endproperty
	a_rule2: assert property (p_rule2) else $error("init pattern wrong"); // see (RULE2)

	property p_rule3;
		@(posedge clk) disable iff (rst)
		state_reg == dobs_pkg::DOBS_ST_WAIT_GOOD |=> pat_reg == dobs_pkg::PAT_ODD;
	endproperty
	a_rule3: assert property (p_rule3) else $error("wait step pattern wrong"); // see (RULE3)

	property p_rule4;
		@(posedge clk) disable iff (rst)
		seq_output_oe == seq_output_val && seq_output_out == 15'h0000;
	endproperty
	a_rule4: assert property (p_rule4) else $error("open drain mapping wrong"); // see (RULE4)

	property p_rule5;
		@(posedge clk) disable iff (rst)
		state_reg == dobs_pkg::DOBS_ST_WAIT_GOOD && !analog_supplies_good
		|=> state_reg == dobs_pkg::DOBS_ST_WAIT_GOOD;
	endproperty
	a_rule5: assert property (p_rule5) else $error("left wait without supplies good"); // see (RULE5)

	sequence s_even_set;
		state_reg == dobs_pkg::DOBS_ST_EVEN;
	endsequence
	property p_rule6;
		@(posedge clk) disable iff (rst)
		s_even_set |=> pat_reg == dobs_pkg::PAT_EVEN && state_reg == dobs_pkg::DOBS_ST_DELAY1;
	endproperty
	a_rule6: assert property (p_rule6) else $error("even pattern wrong"); // see (RULE6)

	property p_rule7;
		@(posedge clk) disable iff (rst)
		$rose(state_reg == dobs_pkg::DOBS_ST_DELAY1) |-> tmr_reg == 32'h0000_0000;
	endproperty
	a_rule7: assert property (p_rule7) else $error("delay timer not cleared"); // see (RULE7)

	property p_rule8;
		@(posedge clk) disable iff (rst)
		state_reg == dobs_pkg::DOBS_ST_ODD |=> pat_reg == dobs_pkg::PAT_ODD3;
	endproperty
	a_rule8: assert property (p_rule8) else $error("odd pattern wrong"); // see (RULE8)

	property p_rule9;
		@(posedge clk) disable iff (rst)
		state_reg == dobs_pkg::DOBS_ST_DELAY2 && tmr_done |=> s_even_set;
	endproperty
	a_rule9: assert property (p_rule9) else $error("loop did not return"); // see (RULE9)

	// age of the current pattern in cycles; read by the timing assertions only
	always_ff @(posedge clk) begin
		if (rst) begin
			hold_cnt_reg <= 32'h0000_0000;
		end else if (pat_change) begin
			hold_cnt_reg <= 32'h0000_0000;
		end else begin
			hold_cnt_reg <= count_up(hold_cnt_reg);
		end
	end

	sequence s_boot;
		state_reg == dobs_pkg::DOBS_ST_INIT ##1
		state_reg == dobs_pkg::DOBS_ST_WAIT_GOOD && pat_reg == dobs_pkg::PAT_INIT ##1
		pat_reg == dobs_pkg::PAT_ODD;
	endsequence
	property p_rule1_order;
		@(posedge clk) disable iff (rst)
		!rst && state_reg == dobs_pkg::DOBS_ST_START |=> s_boot;
	endproperty
	a_rule1_order: assert property (p_rule1_order) else $error("boot order wrong"); // see (RULE1)

	property p_rule5_go;
		@(posedge clk) disable iff (rst)
		state_reg == dobs_pkg::DOBS_ST_WAIT_GOOD && pat_reg == dobs_pkg::PAT_ODD
		&& analog_supplies_good |=> s_even_set;
	endproperty
	a_rule5_go: assert property (p_rule5_go) else $error("good did not advance"); // see (RULE5)

	sequence s_delay1_hold;
		state_reg == dobs_pkg::DOBS_ST_DELAY1 && pat_reg == dobs_pkg::PAT_EVEN;
	endsequence
	sequence s_delay2_hold;
		state_reg == dobs_pkg::DOBS_ST_DELAY2 && pat_reg == dobs_pkg::PAT_ODD3;
	endsequence
	property p_rule7_wait1;
		@(posedge clk) disable iff (rst)
		state_reg == dobs_pkg::DOBS_ST_DELAY1 && !tmr_done |=> s_delay1_hold;
	endproperty
	a_rule7_wait1: assert property (p_rule7_wait1) else $error("delay1 short"); // see (RULE7)

	property p_rule7_wait2;
		@(posedge clk) disable iff (rst)
		state_reg == dobs_pkg::DOBS_ST_DELAY2 && !tmr_done |=> s_delay2_hold;
	endproperty
	a_rule7_wait2: assert property (p_rule7_wait2) else $error("delay2 short"); // see (RULE7)

	property p_rule7_exit;
		@(posedge clk) disable iff (rst)
		state_reg == dobs_pkg::DOBS_ST_DELAY1 && tmr_done
		|=> state_reg == dobs_pkg::DOBS_ST_ODD ##1 s_delay2_hold;
	endproperty
	a_rule7_exit: assert property (p_rule7_exit) else $error("delay1 no exit"); // see (RULE7)

	// the age reaches DELAY_CYC just as the step that loads the next pattern runs
	property p_rule7_len1;
		@(posedge clk) disable iff (rst)
		state_reg == dobs_pkg::DOBS_ST_ODD |-> hold_cnt_reg == DELAY_CYC;
	endproperty
	a_rule7_len1: assert property (p_rule7_len1) else $error("even time wrong"); // see (RULE7)

	property p_rule7_len2;
		@(posedge clk) disable iff (rst)
		state_reg == dobs_pkg::DOBS_ST_EVEN && pat_reg == dobs_pkg::PAT_ODD3
		|-> hold_cnt_reg == DELAY_CYC;
	endproperty
	a_rule7_len2: assert property (p_rule7_len2) else $error("odd time wrong"); // see (RULE7)
endmodule

/* File: design/dobs_pkg.sv */
// constants for the demo output blinker sequencer
// assumes a 25 MHz system clock
package dobs_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	// loop delay in microseconds (524.29 ms)
	localparam int unsigned LOOP_DELAY_US = 524290;
	localparam longint unsigned LOOP_DELAY_CYC_L = (longint'(LOOP_DELAY_US) * CLK_HZ) / 1000000;
	localparam int unsigned LOOP_DELAY_CYC = int'(LOOP_DELAY_CYC_L);
	localparam int OUT_W = 15;
	// bit n drives seq_output_n; bits 0..2 stay 0, bit 3 only in the second loop pattern
	localparam logic [14:0] PAT_RESET = 15'h0000;
	localparam logic [14:0] PAT_INIT = 15'h0050;
	localparam logic [14:0] PAT_ODD = 15'h2AA0;
	localparam logic [14:0] PAT_EVEN = 15'h5550;
	localparam logic [14:0] PAT_ODD3 = 15'h2AA8;
	typedef enum logic [2:0] {
		DOBS_ST_START,
		DOBS_ST_INIT,
		DOBS_ST_WAIT_GOOD,
		DOBS_ST_EVEN,
		DOBS_ST_DELAY1,
		DOBS_ST_ODD,
		DOBS_ST_DELAY2
	} dobs_state_t;
endpackage

/* File: verif/dobs_supply_model.sv */
// supply monitor stand-in: good pulses high some cycles after reset
// assumes synchronous reset on the shared clock
`timescale 1ns/1ps
module dobs_supply_model #(
	parameter int GOOD_DLY = 30
) (
	input wire logic clk, // system clock
	input wire logic rst, // sync reset, active high
	output logic analog_supplies_good // supplies good level
);
	int cnt_reg;
	// late rise stalls the wait step; early fall shows the loop ignores it
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= 0;
			analog_supplies_good <= 1'b0;
		end else begin
			cnt_reg <= (cnt_reg < 1000) ? cnt_reg + 1 : cnt_reg;
			analog_supplies_good <= (cnt_reg >= GOOD_DLY) && (cnt_reg < GOOD_DLY + 8);
		end
	end
endmodule

/* File: verif/dobs_sequencer_tb.sv */
// bench for the blinker sequencer: pattern order, supply wait, loop timing
// assumes the supply model as far side
`timescale 1ns/1ps
module dobs_sequencer_tb;
	localparam int DLY = 10;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic good;
	logic [14:0] p_out, p_oe, p_val;
	int num_errors = 0;
	int n_tests = 0;
	int n;
	always #20 clk = ~clk;
	dobs_supply_model #(.GOOD_DLY(30)) sup_u (.clk(clk), .rst(rst), .analog_supplies_good(good));
	dobs_sequencer #(.DELAY_CYC(DLY)) dut_u (.clk(clk), .rst(rst), .analog_supplies_good(good),
		.seq_output_out(p_out), .seq_output_oe(p_oe), .seq_output_val(p_val));
	task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// cycles until the pattern shows, bounded
	task automatic wait_pat(input logic [14:0] pat, output int c);
		c = 0;
		while (p_val !== pat) begin
			@(negedge clk);
			c++;
			if (c > 200) begin
				num_errors++;
				$display("FAIL %0t: pattern timeout", $time);
				end_sim();
			end
		end
	endtask
	// expects rst high on entry and releases it itself
	task automatic test_init;
		@(negedge clk);
		chk(p_oe, dobs_pkg::PAT_RESET);
		chk(p_val, dobs_pkg::PAT_RESET);
		@(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk(p_val, dobs_pkg::PAT_RESET);
		@(negedge clk);
		chk(p_val, dobs_pkg::PAT_INIT);
		chk(p_oe, dobs_pkg::PAT_INIT);
		chk(p_out, 15'h0000);
		@(negedge clk);
		chk(p_val, dobs_pkg::PAT_ODD);
		$display("init done");
	endtask
	task automatic test_wait;
		repeat (20) begin
			@(negedge clk);
			chk(p_val, dobs_pkg::PAT_ODD);
		end
		wait_pat(dobs_pkg::PAT_EVEN, n);
		chk(p_oe, dobs_pkg::PAT_EVEN);
		$display("wait done");
	endtask
	task automatic test_loop;
		repeat (3) begin
			wait_pat(dobs_pkg::PAT_ODD3, n);
			chk(15'(n), 15'(DLY + 1));
			chk(p_oe, dobs_pkg::PAT_ODD3);
			wait_pat(dobs_pkg::PAT_EVEN, n);
			chk(15'(n), 15'(DLY + 1));
		end
		$display("loop done");
	endtask
	// reset in mid-loop: outputs drop, then the program restarts at its first step
	task automatic test_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		test_init();
		test_wait();
		$display("reset done");
	endtask
	initial begin
		repeat (9) @(posedge clk);
		test_init();
		test_wait();
		test_loop();
		test_reset();
		test_loop();
		end_sim();
	end
endmodule
